/* shared/bmd_pkg.sv */
// Purpose: constants for the banked memory map decoder
// Assumes: 8-bit data path, 14-bit instruction words
// Notes:   offsets are bank-relative 7-bit file addresses
package bmd_pkg;
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int PMEM_SMALL = 1024;
  localparam int PMEM_LARGE = 2048;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_FLAGS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_LATCH = 7'h0a;
  localparam logic [6:0] OFS_INTCTL = 7'h0b;
  localparam logic [6:0] GPR0_LO = 7'h20;
  localparam logic [6:0] GPR1_LO = 7'h20;
  localparam logic [6:0] GPR1_HI = 7'h3f;
  localparam int BANK_HI_BIT = 6;
  localparam int BANK_LO_BIT = 5;
  localparam int LATCH_W = 5;
  localparam int GPR_WORDS = 128;
  localparam logic [7:0] FLAGS_RST = 8'h18;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage : bmd_pkg

/* shared/bmd_ram_if.sv */
// Purpose: port bundle between decoder and general purpose ram
// Assumes: single clock, one access per cycle
// Notes:   read data registered inside the ram
`timescale 1ns/1ns
interface bmd_ram_if;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : bmd_ram_if

/* design/bmd_gpr_ram.sv */
// Purpose: static ram holding the general purpose registers of both banks
// Assumes: synchronous write and registered read
// Notes:   96 bank0 bytes at words 0..95, 32 bank1 bytes at 96..127
`timescale 1ns/1ns
module bmd_gpr_ram
  import bmd_pkg::*;
#(
  parameter int DEPTH = GPR_WORDS
)(
  input  wire logic mclk,
  bmd_ram_if.mem    rp
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;

  always_ff @(posedge mclk)
  begin
    if (rp.we)
    begin
      mem_r[rp.addr] <= rp.wdata;
    end
    rdata_r <= mem_r[rp.addr];
  end

  assign rp.rdata = rdata_r;
endmodule : bmd_gpr_ram

/* design/bmd_decoder.sv */
// Operation
// - program counter is 13 bits, reaching an 8K by 14 space
// - implemented program depth is a parameter, 1K or 2K words
// - fetches beyond implemented memory wrap, upper counter bits ignored
// - reset starts at 0000h, accepted interrupt loads 0004h
// - program and data buses are independent and work concurrently
// - flags bits 6:5 pick the bank; 00 bank0, 01 bank1
// - banks span 128 bytes with special registers at the bottom
// - ram above special registers: 96 bytes bank0, 32 bytes bank1
// - indirect port, pcl, flags, pointer, latch, intctl mirrored
// - access direct by bank plus offset, or indirect via pointer
// - indirect port access uses pointer contents as data address
// - latch buffers the upper 5 counter bits, is not the counter
//
// Purpose: program and data memory map decode for an 8-bit core
// Assumes: core drives one data access per cycle; read data one cycle later
// Notes:   peripheral registers outside the core set decode as unimplemented
`timescale 1ns/1ns
module bmd_decoder
  import bmd_pkg::*;
#(
  parameter int PMEM_WORDS = PMEM_SMALL
)(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              pc_step,
  input  wire logic              pc_int_take,
  input  wire logic              pc_jump,
  input  wire logic [10:0]       pc_jump_lo,
  output logic      [PC_W-1:0]   program_counter,
  output logic      [PC_W-1:0]   pmem_addr,
  input  wire logic              dm_rd,
  input  wire logic              dm_wr,
  input  wire logic [6:0]        dm_ofs,
  input  wire logic [7:0]        dm_wdata,
  output logic      [7:0]        dm_rdata,
  output logic      [7:0]        flags_out,
  output logic      [7:0]        intctl_out
);
  localparam int AW = $clog2(PMEM_WORDS);
  // bank1 ram words follow the 96 bank0 bytes in the shared array
  localparam logic [6:0] GPR1_BASE = 7'h60;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [PC_W-1:0]    pc_r;
  logic [7:0]         flags_r;
  logic [7:0]         pointer_r;
  logic [LATCH_W-1:0] latch_r;
  logic [7:0]         intctl_r;
  logic [7:0]         sfr_rd_r;
  logic               sfr_hit_r;
  logic               bank1;
  logic               bank_ok;
  logic [7:0]         eff_addr;
  logic [6:0]         eff_ofs;
  logic               eff_ok;
  logic               ind;

  bmd_ram_if ram_bus ();

  bmd_gpr_ram #(.DEPTH(GPR_WORDS)) u_ram (
    .mclk (mclk),
    .rp   (ram_bus.mem)
  );

  // ---------------------------------------------------------------------
  // program side
  // ---------------------------------------------------------------------
  // own bus, never stalled by data accesses
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pc_r <= RESET_VEC;
    else if (pc_int_take)
      pc_r <= INT_VEC;
    else if (dm_wr && eff_ofs == OFS_PCL && eff_ok)
      pc_r <= {latch_r, dm_wdata};
    else if (pc_jump)
      pc_r <= {latch_r[LATCH_W-1:3], pc_jump_lo};
    else if (pc_step)
      pc_r <= pc_r + 13'h0001;
  end

  assign program_counter = pc_r;
  // upper bits dropped so fetches alias into the array
  assign pmem_addr = {{(PC_W-AW){1'b0}}, pc_r[AW-1:0]};

  // ---------------------------------------------------------------------
  // data address decode
  // ---------------------------------------------------------------------
  assign ind = (dm_ofs == OFS_INDIRECT);
  // upper bit set names an absent bank; direct accesses then hit nothing, indirect ones still decode
  assign bank_ok = ~flags_r[BANK_HI_BIT];
  assign bank1 = flags_r[BANK_LO_BIT];
  assign eff_addr = ind ? pointer_r : {bank1, dm_ofs};
  assign eff_ofs = eff_addr[6:0];
  assign eff_ok = (ind || bank_ok) && !(ind && pointer_r[6:0] == OFS_INDIRECT);

  logic       gpr_hit;
  logic [6:0] gpr_idx;

  always_comb
  begin
    gpr_hit = 1'b0;
    gpr_idx = 7'h00;
    if (!eff_addr[7] && eff_ofs >= GPR0_LO)
    begin
      gpr_hit = 1'b1;
      gpr_idx = eff_ofs - GPR0_LO;
    end
    else if (eff_addr[7] && eff_ofs >= GPR1_LO && eff_ofs <= GPR1_HI)
    begin
      gpr_hit = 1'b1;
      gpr_idx = 7'(eff_ofs - GPR1_LO + GPR1_BASE);
    end
  end

  assign ram_bus.we = dm_wr && eff_ok && gpr_hit;
  assign ram_bus.addr = gpr_idx;
  assign ram_bus.wdata = dm_wdata;

  // ---------------------------------------------------------------------
  // mirrored core registers, one copy regardless of bank
  // ---------------------------------------------------------------------
  logic sfr_wr;
  assign sfr_wr = dm_wr && eff_ok;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      flags_r <= FLAGS_RST;
    else if (sfr_wr && eff_ofs == OFS_FLAGS)
      flags_r <= dm_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pointer_r <= ZERO8;
    else if (sfr_wr && eff_ofs == OFS_POINTER)
      pointer_r <= dm_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      latch_r <= '0;
    else if (sfr_wr && eff_ofs == OFS_LATCH)
      latch_r <= dm_wdata[LATCH_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      intctl_r <= ZERO8;
    else if (sfr_wr && eff_ofs == OFS_INTCTL)
      intctl_r <= dm_wdata;
  end

  // ---------------------------------------------------------------------
  // read return, one cycle after the request
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sfr_rd_r  <= ZERO8;
      sfr_hit_r <= 1'b0;
    end
    else
    begin
      // only a read selects the ram word; idle cycles return zero
      sfr_hit_r <= dm_rd && gpr_hit && eff_ok;
      sfr_rd_r  <= ZERO8;
      if (dm_rd && eff_ok)
      begin
        case (eff_ofs)
          OFS_PCL:     sfr_rd_r <= pc_r[7:0];
          OFS_FLAGS:   sfr_rd_r <= flags_r;
          OFS_POINTER: sfr_rd_r <= pointer_r;
          OFS_LATCH:   sfr_rd_r <= {3'b000, latch_r};
          OFS_INTCTL:  sfr_rd_r <= intctl_r;
          default:     sfr_rd_r <= ZERO8;
        endcase
      end
    end
  end

  assign dm_rdata = sfr_hit_r ? ram_bus.rdata : sfr_rd_r;
  assign flags_out = flags_r;
  assign intctl_out = intctl_r;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  a_reset_vector: assert property (@(posedge mclk)
    sys_rst |=> pc_r == RESET_VEC) else $error("pc not at reset vector");
  a_int_vector: assert property (@(posedge mclk) disable iff (sys_rst)
    pc_int_take |=> pc_r == INT_VEC) else $error("pc not at interrupt vector");
  a_pc_wrap: assert property (@(posedge mclk)
    pmem_addr[PC_W-1:AW] == '0) else $error("fetch address beyond array");
  a_latch_load: assert property (@(posedge mclk) disable iff (sys_rst)
    (dm_wr && eff_ok && eff_ofs == OFS_PCL && !pc_int_take)
      |=> pc_r[12:8] == $past(latch_r)) else $error("pcl write lost latch");
  a_bank_absent: assert property (@(posedge mclk) disable iff (sys_rst)
    (!ind && flags_r[BANK_HI_BIT]) |-> !ram_bus.we) else $error("absent bank written");
  a_mirror_flags: assert property (@(posedge mclk) disable iff (sys_rst)
    (dm_wr && eff_ok && eff_ofs == OFS_FLAGS) |=> flags_r == $past(dm_wdata))
    else $error("mirrored flags write missed");
  a_unimpl_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (dm_rd && !ind && eff_ofs == 7'h08) |=> dm_rdata == ZERO8)
    else $error("unimplemented read not zero");
  a_ptr_redirect: assert property (@(posedge mclk) disable iff (sys_rst)
    (dm_wr && ind && pointer_r == 8'h04) |=> pointer_r == $past(dm_wdata))
    else $error("indirect write missed target");

  sequence s_plain_step;
    pc_step && !pc_int_take && !pc_jump && !(dm_wr && eff_ok && eff_ofs == OFS_PCL);
  endsequence

  a_fetch_alias: assert property (@(posedge mclk) disable iff (sys_rst)
    s_plain_step |=> pmem_addr[AW-1:0] == AW'($past(pmem_addr[AW-1:0]) + 1'b1))
    else $error("fetch address did not alias");
endmodule : bmd_decoder

/* bench/bmd_core_model.sv */
// Purpose: core-side model issuing fetch controls and data accesses
// Assumes: requests launched on a rising edge and held until taken
// Notes:   released write data shows the inverse of the last value
`timescale 1ns/1ns
module bmd_core_model (
  input  wire logic        mclk,
  output logic             pc_step,
  output logic             pc_int_take,
  output logic             pc_jump,
  output logic      [10:0] pc_jump_lo,
  output logic             dm_rd,
  output logic             dm_wr,
  output logic      [6:0]  dm_ofs,
  output logic      [7:0]  dm_wdata,
  input  wire logic [7:0]  dm_rdata
);
  initial
  begin
    {pc_step, pc_int_take, pc_jump, dm_rd, dm_wr} = '0;
    pc_jump_lo = '0;
    dm_ofs = '0;
    dm_wdata = '0;
  end

  // one data access; read data is taken once the answering edge has settled
  task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk);
    dm_rd <= !w;
    dm_wr <= w;
    dm_ofs <= o;
    dm_wdata <= d;
    @(posedge mclk);
    dm_rd <= 1'b0;
    dm_wr <= 1'b0;
    dm_wdata <= ~d;
    #1 q = dm_rdata;
  endtask : acc

  // k is {step, interrupt, jump}, held for exactly one edge
  task automatic ctl(input logic [2:0] k, input logic [10:0] lo);
    @(posedge mclk);
    {pc_step, pc_int_take, pc_jump} <= k;
    pc_jump_lo <= lo;
    @(posedge mclk);
    {pc_step, pc_int_take, pc_jump} <= 3'b000;
    #1;
  endtask : ctl
endmodule : bmd_core_model

/* bench/tb_top.sv */
// Purpose: self-checking bench for the memory map decoder
// Assumes: small program memory variant, core model drives all requests
// Notes:   expectations come from package constants and the address map
`timescale 1ns/1ns
module tb_top
  import bmd_pkg::*;
;
  logic            mclk;
  logic            sys_rst;
  logic            pc_step, pc_int_take, pc_jump, dm_rd, dm_wr;
  logic [10:0]     pc_jump_lo;
  logic [6:0]      dm_ofs;
  logic [7:0]      dm_wdata, dm_rdata, flags_out;
  logic [PC_W-1:0] program_counter, pmem_addr, pmem_addr_large;
  logic [7:0]      intctl_out;
  int              n_mismatch = 0;
  int              tests_run = 0;

  bmd_decoder #(.PMEM_WORDS(PMEM_SMALL)) dut (
    .mclk, .sys_rst, .pc_step, .pc_int_take, .pc_jump, .pc_jump_lo,
    .program_counter, .pmem_addr, .dm_rd, .dm_wr, .dm_ofs, .dm_wdata,
    .dm_rdata, .flags_out, .intctl_out);
  // larger variant shares every input; only its fetch address is judged
  bmd_decoder #(.PMEM_WORDS(PMEM_LARGE)) dut_large (
    .mclk, .sys_rst, .pc_step, .pc_int_take, .pc_jump, .pc_jump_lo,
    .program_counter(), .pmem_addr(pmem_addr_large), .dm_rd, .dm_wr, .dm_ofs,
    .dm_wdata, .dm_rdata(), .flags_out(), .intctl_out());
  bmd_core_model core (
    .mclk, .pc_step, .pc_int_take, .pc_jump, .pc_jump_lo,
    .dm_rd, .dm_wr, .dm_ofs, .dm_wdata, .dm_rdata);

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    logic [7:0] q;
    core.acc(1'b1, o, d, q);
  endtask : wr

  task automatic rd_chk(input logic [6:0] o, input logic [7:0] e);
    logic [7:0] q;
    core.acc(1'b0, o, 8'h00, q);
    check(16'(q), 16'(e));
  endtask : rd_chk

  task automatic test_done;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check(16'(program_counter), 16'(RESET_VEC));
    check(16'(pmem_addr), 16'h0000);
    rd_chk(OFS_FLAGS, FLAGS_RST);
    rd_chk(OFS_POINTER, ZERO8);
  endtask : t_reset

  // latch must not move the counter; jump to the top then wrap both ways
  task automatic t_prog;
    wr(OFS_LATCH, 8'h1f);
    check(16'(program_counter), 16'h0000);
    core.ctl(3'b001, 11'h7ff);
    check(16'(program_counter), 16'h1fff);
    check(16'(pmem_addr), 16'(PMEM_SMALL - 1));
    check(16'(pmem_addr_large), 16'(PMEM_LARGE - 1));
    core.ctl(3'b100, 11'h000);
    check(16'(program_counter), 16'h0000);
    wr(OFS_PCL, 8'h34);
    check(16'(program_counter), 16'h1f34);
    check(16'(pmem_addr), 16'h0334);
    check(16'(pmem_addr_large), 16'h0734);
    core.ctl(3'b010, 11'h000);
    check(16'(program_counter), 16'(INT_VEC));
  endtask : t_prog

  task automatic t_concur;
    fork
      wr(7'h21, 8'h77);
      core.ctl(3'b100, 11'h000);
    join
    check(16'(program_counter), 16'(INT_VEC + 1));
    rd_chk(7'h21, 8'h77);
  endtask : t_concur

  task automatic t_banks;
    wr(GPR0_LO, 8'h11);
    wr(7'h7f, 8'h22);
    wr(OFS_FLAGS, 8'h20);
    check(16'(flags_out[6:5]), 16'h0001);
    wr(GPR1_LO, 8'h33);
    wr(GPR1_HI, 8'h44);
    wr(7'h40, 8'h55);
    rd_chk(7'h40, ZERO8);
    rd_chk(GPR1_LO, 8'h33);
    rd_chk(GPR1_HI, 8'h44);
    wr(OFS_POINTER, 8'ha0);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(OFS_POINTER, 8'ha0);
    rd_chk(GPR0_LO, 8'h11);
    rd_chk(7'h7f, 8'h22);
    rd_chk(7'h08, ZERO8);
  endtask : t_banks

  // pointer a0h lands in bank 1 ram; 7fh is read through both port mirrors
  task automatic t_indirect;
    wr(OFS_INDIRECT, 8'h66);
    wr(OFS_FLAGS, 8'h20);
    rd_chk(GPR1_LO, 8'h66);
    wr(OFS_POINTER, 8'h04);
    wr(OFS_INDIRECT, 8'h7f);
    rd_chk(OFS_POINTER, 8'h7f);
    rd_chk(OFS_INDIRECT, 8'h22);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(OFS_INDIRECT, 8'h22);
  endtask : t_indirect

  // upper select bit set drops direct accesses; the pointer still reaches flags
  task automatic t_absent;
    wr(OFS_POINTER, 8'h03);
    wr(OFS_INTCTL, 8'h5a);
    check(16'(intctl_out), 16'h005a);
    wr(OFS_FLAGS, 8'h40);
    wr(GPR0_LO, 8'h99);
    rd_chk(GPR0_LO, ZERO8);
    wr(OFS_INDIRECT, 8'h20);
    check(16'(flags_out), 16'h0020);
    rd_chk(OFS_INTCTL, 8'h5a);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(GPR0_LO, 8'h11);
  endtask : t_absent

  // reset in mid-run must restore flags, intctl, counter and latch
  task automatic t_rerst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    check(16'(flags_out), 16'(FLAGS_RST));
    check(16'(intctl_out), 16'h0000);
    check(16'(program_counter), 16'(RESET_VEC));
    rd_chk(OFS_LATCH, ZERO8);
  endtask : t_rerst

  initial
  begin
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_prog();
    t_concur();
    t_banks();
    t_indirect();
    t_absent();
    t_rerst();
    test_done();
  end

  // the whole run needs under a hundred cycles
  initial
  begin
    #20000;
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
